//--- clock_gen_checker_properties.sv
// Purpose: Port-level properties of the clock generator control
// Assumes: Outputs registered, one or two edges behind their cause
// Notes: Bound to the design top module
`timescale 1ns/1ns
`default_nettype none
module clock_gen_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stop_mode,
  input wire logic stop_oscillator_option,
  input wire logic internal_clock_dead,
  input wire logic external_clock_dead,
  input wire logic filter_valid,
  input wire logic [7:0] filter_stage,
  input wire logic monitor_irq,
  input wire logic clock_select,
  input wire logic internal_gen_run,
  input wire logic external_gen_run,
  input wire logic oscillator_output_enable,
  input wire logic [6:0] multiplier_effective,
  input wire logic [3:0] divider_effective,
  input wire logic [7:0] stage_out
);
  // Internal reset trails nrst by two flops, so settle before judging runs
  logic [2:0] up;
  logic ok;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  assign ok = up == 3'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_calm;
    !$past(stop_mode) && !$past(stop_mode, 2);
  endsequence
  sequence s_fill;
    filter_valid && internal_gen_run ##1 filter_valid && internal_gen_run && $stable(filter_stage);
  endsequence
  property p_bus; hreadyout && !hresp; endproperty
  property p_div; divider_effective <= 4'h9; endproperty
  property p_mult; multiplier_effective != 7'h00; endproperty
  property p_stop;
    stop_mode && !stop_oscillator_option |=> !oscillator_output_enable && !internal_gen_run && !external_gen_run;
  endproperty
  property p_edead; ok && external_clock_dead && !internal_clock_dead |-> ##[1:2] !clock_select; endproperty
  property p_stage; s_fill |=> stage_out == $past(filter_stage); endproperty
  property p_erun;
    ((ok && clock_select && $past(clock_select)) and s_calm) |-> external_gen_run;
  endproperty
  property p_irun;
    ((ok && !clock_select && !$past(clock_select)) and s_calm) |-> internal_gen_run;
  endproperty
  property p_irq; (monitor_irq and s_calm) |-> internal_gen_run && external_gen_run; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or okay");
  a_div: assert property (p_div) else $error("divider above cap");
  a_mult: assert property (p_mult) else $error("multiplier shows zero");
  a_stop: assert property (p_stop) else $error("clocks run in stop");
  a_edead: assert property (p_edead) else $error("select kept external");
  a_stage: assert property (p_stage) else $error("stage not from filter");
  a_erun: assert property (p_erun) else $error("external off while selected");
  a_irun: assert property (p_irun) else $error("internal off while not selected");
  a_irq: assert property (p_irq) else $error("irq without monitor on");
endmodule
bind clock_generator_control clock_gen_checker u_clock_gen_checker (.clk, .nrst, .hreadyout, .hresp,
  .stop_mode, .stop_oscillator_option, .internal_clock_dead, .external_clock_dead, .filter_valid,
  .filter_stage, .monitor_irq, .clock_select, .internal_gen_run, .external_gen_run,
  .oscillator_output_enable, .multiplier_effective, .divider_effective, .stage_out);
`default_nettype wire

//--- clock_gen_pkg.sv
// Purpose: Types shared by the clock generator control
// Assumes: Used together with clock_gen_regs.svh
// Notes: Types only
package clock_gen_pkg;

  typedef struct packed {
    logic irq_en;
    logic flag;
    logic mon_on;
    logic sel;
    logic int_en;
    logic int_stable;
    logic ext_en;
    logic ext_stable;
  } control_type;

  typedef struct packed {
    logic [6:0] multiplier_factor;
    logic [7:0] trim_factor;
    logic [3:0] divider_field;
    logic [7:0] stage_field;
  } osc_setting_type;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ = 3'b100
  } bus_state_type;

endpackage

//--- clock_gen_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts for the clock generator control
// Assumes: 32-bit AHB-Lite word registers, byte address = four times the register index
// Notes: Definitions only
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH

// Register indices count 32-bit words, so every index is scaled by four on the bus
`define CG_IDX_CONTROL 16'h0000
`define CG_IDX_MULT 16'h0001
`define CG_IDX_TRIM 16'h0002
`define CG_IDX_DIVIDER 16'h0003
`define CG_IDX_STAGE 16'h0004
`define CG_IDX_STORE_5V 16'hFF80
`define CG_IDX_STORE_3V 16'hFF81
`define CG_OFS_CONTROL 32'h0000_0000
`define CG_OFS_MULT 32'h0000_0004
`define CG_OFS_TRIM 32'h0000_0008
`define CG_OFS_DIVIDER 32'h0000_000C
`define CG_OFS_STAGE 32'h0000_0010
`define CG_OFS_STORE_5V 32'h0003_FE00
`define CG_OFS_STORE_3V 32'h0003_FE04

`define CG_BIT_IRQ_EN 7
`define CG_BIT_FLAG 6
`define CG_BIT_MON_ON 5
`define CG_BIT_SEL 4
`define CG_BIT_INT_EN 3
`define CG_BIT_INT_STABLE 2
`define CG_BIT_EXT_EN 1
`define CG_BIT_EXT_STABLE 0

`define CG_RESET_MULT 7'h15
`define CG_RESET_TRIM 8'h80
`define CG_DIV_MAX 4'h9
`define CG_EXT_STABLE_CYCLES 4096
`define CG_EXT_STABLE_CYCLES_FAST 16

`endif

//--- clock_generator_control.sv
// Purpose: Control and status logic of an on-chip clock generator, reached over AHB-Lite
// Assumes: Clock monitor, stability detector, loop filter and oscillator sit outside and report by level pins
// Notes: Store bytes come from nonvolatile storage as input buses; writes to them are dropped
//
// What this block does
// - Interrupt when enable and flag both set
// - Irq enable settable only after monitor on
// - Monitor sets flag on dead clock
// - Flag cleared by read-then-write-zero, or monitor off
// - Monitor on needs both enables, both stable
// - Flag set holds monitor on
// - Monitor off forced by enables, stop, reset
// - Select picks external or internal clock
// - Select changes only after target clock stable
// - Dead clocks or disabled enables force select
// - Internal enable clear needs select, monitor off
// - Internal stable tracks lock, cleared by events
// - External enable clear needs select clear, monitor clear
// - External stable after 4096 external cycles
// - Multiplier seven bits, zero acts one, reset 21
// - Multiplier, trim writes ignored while monitor on
// - Trim eight bits, centre code at reset
// - Divider stages, loop filter drives, cap nine
// - Stage write refused while internal enable set
// - Stop without option halts clocks low
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_regs.svh"

module clock_generator_control #(
  parameter int unsigned EXT_STABLE_CYCLES = `CG_EXT_STABLE_CYCLES,
  parameter logic [7:0] STORE_5V_DEFAULT = 8'h00,
  parameter logic [7:0] STORE_3V_DEFAULT = 8'h00
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic stop_mode,
  input wire logic stop_oscillator_option,
  input wire logic internal_clock_dead,
  input wire logic external_clock_dead,
  input wire logic internal_lock,
  input wire logic external_clock_tick,
  input wire logic filter_valid,
  input wire logic [3:0] filter_divider,
  input wire logic [7:0] filter_stage,
  input wire logic [7:0] store_5v,
  input wire logic [7:0] store_3v,
  output logic monitor_irq,
  output logic clock_select,
  output logic internal_gen_run,
  output logic external_gen_run,
  output logic oscillator_output_enable,
  output logic [6:0] multiplier_effective,
  output logic [7:0] oscillator_trim_out,
  output logic [3:0] divider_effective,
  output logic [7:0] stage_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and decode helpers

  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic at(input logic [15:0] a, input logic [15:0] ofs);
    at = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, OKAY always

  clock_gen_pkg::bus_state_type bus_state;
  logic [15:0] addr_q;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= clock_gen_pkg::BUS_IDLE;
      addr_q <= 16'h0000;
    end else if (take) begin
      bus_state <= hwrite ? clock_gen_pkg::BUS_WRITE : clock_gen_pkg::BUS_READ;
      addr_q <= haddr[17:2];
    end else if (hready) begin
      bus_state <= clock_gen_pkg::BUS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  logic wr_ctl;
  logic wr_mult;
  logic wr_trim;
  logic wr_div;
  logic wr_stage;
  logic rd_ctl;

  always_comb begin
    wr_ctl = 1'b0;
    wr_mult = 1'b0;
    wr_trim = 1'b0;
    wr_div = 1'b0;
    wr_stage = 1'b0;
    case (bus_state)
      clock_gen_pkg::BUS_WRITE: begin
        wr_ctl = at(addr_q, `CG_IDX_CONTROL);
        wr_mult = at(addr_q, `CG_IDX_MULT);
        wr_trim = at(addr_q, `CG_IDX_TRIM);
        wr_div = at(addr_q, `CG_IDX_DIVIDER);
        wr_stage = at(addr_q, `CG_IDX_STAGE);
      end
      default: begin
        wr_ctl = 1'b0;
      end
    endcase
  end
  assign rd_ctl = take && !hwrite && at(haddr[17:2], `CG_IDX_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  clock_gen_pkg::control_type ctl;
  clock_gen_pkg::control_type prev;
  clock_gen_pkg::control_type w;
  logic stop_kill;
  logic flag_armed;
  logic [12:0] ext_count;

  assign stop_kill = stop_mode && !stop_oscillator_option;
  assign w = clock_gen_pkg::control_type'(hwdata[7:0]);

  // One-cycle history: bits must have stood a bus cycle before a change is allowed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= ctl;
    end
  end

  // Read of a set flag arms the software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_armed <= 1'b0;
    end else if (!ctl.flag) begin
      flag_armed <= 1'b0;
    end else if (rd_ctl) begin
      flag_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_count <= '0;
    end else if (!ctl.ext_en || external_clock_dead || stop_kill) begin
      ext_count <= '0;
    end else if (external_clock_tick && ext_count < 13'(EXT_STABLE_CYCLES)) begin
      ext_count <= ext_count + 13'd1;
    end
  end

  clock_gen_pkg::control_type next_ctl;

  always_comb begin
    next_ctl = ctl;
    // Flag: set wins over the software clear
    if (wr_ctl && !w.flag && flag_armed) begin
      next_ctl.flag = 1'b0;
    end
    if (ctl.mon_on && (internal_clock_dead || external_clock_dead)) begin
      next_ctl.flag = 1'b1;
    end
    if (!ctl.mon_on) begin
      next_ctl.flag = 1'b0;
    end
    // Monitor on
    if (wr_ctl) begin
      if (!w.mon_on) begin
        next_ctl.mon_on = 1'b0;
      end else if (prev.int_en && prev.ext_en && prev.int_stable && prev.ext_stable &&
                   ctl.int_en && ctl.ext_en && ctl.int_stable && ctl.ext_stable) begin
        next_ctl.mon_on = 1'b1;
      end
    end
    if (ctl.flag) begin
      next_ctl.mon_on = 1'b1;
    end
    if (!ctl.int_en || !ctl.ext_en || stop_kill) begin
      next_ctl.mon_on = 1'b0;
    end
    // Interrupt enable
    if (wr_ctl) begin
      next_ctl.irq_en = w.irq_en && ctl.mon_on && prev.mon_on;
    end
    if (!next_ctl.mon_on) begin
      next_ctl.irq_en = 1'b0;
    end
    // Clock select
    if (wr_ctl) begin
      if (w.sel && prev.ext_en && prev.ext_stable && ctl.ext_en && ctl.ext_stable) begin
        next_ctl.sel = 1'b1;
      end else if (!w.sel && prev.int_en && prev.int_stable && ctl.int_en && ctl.int_stable) begin
        next_ctl.sel = 1'b0;
      end
    end
    if (internal_clock_dead || !ctl.int_en) begin
      next_ctl.sel = 1'b1;
    end
    if (external_clock_dead || !ctl.ext_en) begin
      next_ctl.sel = 1'b0;
    end
    // Internal enable
    if (wr_ctl) begin
      if (w.int_en) begin
        next_ctl.int_en = 1'b1;
      end else if (prev.sel && !prev.mon_on && ctl.sel && !ctl.mon_on) begin
        next_ctl.int_en = 1'b0;
      end
    end
    if (ctl.mon_on || !ctl.sel) begin
      next_ctl.int_en = 1'b1;
    end
    // External enable
    if (wr_ctl) begin
      if (w.ext_en) begin
        next_ctl.ext_en = 1'b1;
      end else if (!prev.sel && !prev.mon_on && !ctl.sel && !ctl.mon_on) begin
        next_ctl.ext_en = 1'b0;
      end
    end
    if (ctl.mon_on || ctl.sel) begin
      next_ctl.ext_en = 1'b1;
    end
    // Stable indicators
    next_ctl.int_stable = internal_lock;
    if (internal_clock_dead || !next_ctl.int_en || ((wr_mult || wr_trim) && !ctl.mon_on) || stop_kill) begin
      next_ctl.int_stable = 1'b0;
    end
    next_ctl.ext_stable = (ext_count >= 13'(EXT_STABLE_CYCLES));
    if (external_clock_dead || !next_ctl.ext_en || stop_kill) begin
      next_ctl.ext_stable = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 8'h08; // Internal enable set, all else clear
    end else begin
      ctl <= next_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator settings

  clock_gen_pkg::osc_setting_type osc;
  logic [6:0] mult_q;
  logic [7:0] trim_q;
  logic [3:0] div_q;
  logic [7:0] stage_q;
  logic div_loaded;
  logic stage_loaded;
  assign osc = {mult_q, trim_q, div_q, stage_q};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_q <= `CG_RESET_MULT;
      trim_q <= `CG_RESET_TRIM;
    end else begin
      if (wr_mult && !ctl.mon_on) begin
        mult_q <= hwdata[6:0];
      end
      if (wr_trim && !ctl.mon_on) begin
        trim_q <= hwdata[7:0];
      end
    end
  end

  // Divider and stage follow the running oscillator, so reset leaves them alone
  always_ff @(posedge clk) begin
    if (ctl.int_en && filter_valid) begin
      div_q <= filter_divider;
      stage_q <= filter_stage;
    end else begin
      if (wr_div && !ctl.int_en) begin
        div_q <= hwdata[3:0];
      end
      if (wr_stage && !ctl.int_en) begin
        stage_q <= hwdata[7:0];
      end
    end
  end

  // Unknown divider and stage contents read as zero until a value really lands; refused writes do not count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_loaded <= 1'b0;
      stage_loaded <= 1'b0;
    end else begin
      div_loaded <= div_loaded || (ctl.int_en && filter_valid) || (wr_div && !ctl.int_en);
      stage_loaded <= stage_loaded || (ctl.int_en && filter_valid) || (wr_stage && !ctl.int_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and outputs

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      if (at(haddr[17:2], `CG_IDX_CONTROL)) begin
        next_rdata[7:0] = ctl;
      end else if (at(haddr[17:2], `CG_IDX_MULT)) begin
        next_rdata[6:0] = osc.multiplier_factor;
      end else if (at(haddr[17:2], `CG_IDX_TRIM)) begin
        next_rdata[7:0] = osc.trim_factor;
      end else if (at(haddr[17:2], `CG_IDX_DIVIDER)) begin
        next_rdata[3:0] = div_loaded ? osc.divider_field : 4'h0;
      end else if (at(haddr[17:2], `CG_IDX_STAGE)) begin
        next_rdata[7:0] = stage_loaded ? osc.stage_field : 8'h00;
      end else if (at(haddr[17:2], `CG_IDX_STORE_5V)) begin
        next_rdata[7:0] = store_5v;
      end else if (at(haddr[17:2], `CG_IDX_STORE_3V)) begin
        next_rdata[7:0] = store_3v;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take) begin
      hrdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_irq <= 1'b0;
      clock_select <= 1'b0;
      internal_gen_run <= 1'b0;
      external_gen_run <= 1'b0;
      oscillator_output_enable <= 1'b0;
      multiplier_effective <= `CG_RESET_MULT;
      oscillator_trim_out <= `CG_RESET_TRIM;
      divider_effective <= 4'h0;
      stage_out <= 8'h00;
    end else begin
      monitor_irq <= next_ctl.irq_en && next_ctl.flag;
      clock_select <= next_ctl.sel;
      internal_gen_run <= next_ctl.int_en && !stop_kill;
      external_gen_run <= next_ctl.ext_en && !stop_kill;
      oscillator_output_enable <= !stop_kill;
      multiplier_effective <= (osc.multiplier_factor == 7'h00) ? 7'h01 : osc.multiplier_factor;
      oscillator_trim_out <= osc.trim_factor;
      divider_effective <= !div_loaded ? 4'h0 :
                           (osc.divider_field > `CG_DIV_MAX) ? `CG_DIV_MAX : osc.divider_field;
      stage_out <= stage_loaded ? osc.stage_field : 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the clock generator control
// Assumes: Zero-wait AHB-Lite slave, short external stable count
// Notes: Store bytes and register data are random with a fixed seed
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_regs.svh"
module tb;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'hc3b6_4372, r = 0;
  logic [1:0] htrans = 0;
  logic stop_mode = 0, stop_oscillator_option = 0, internal_clock_dead = 0, external_clock_dead = 0;
  logic internal_lock = 0, external_clock_tick = 0, filter_valid = 0;
  logic [3:0] filter_divider = 0, divider_effective;
  logic [7:0] filter_stage = 0, store_5v = 0, store_3v = 0, oscillator_trim_out, stage_out;
  logic hreadyout, hresp, monitor_irq, clock_select, internal_gen_run, external_gen_run;
  logic oscillator_output_enable;
  logic [6:0] multiplier_effective;
  int n_mismatch = 0, checks = 0;
  assign hready = hreadyout;
  clock_generator_control #(.EXT_STABLE_CYCLES(16)) u_clock_generator_control (.clk, .nrst, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .stop_mode,
    .stop_oscillator_option, .internal_clock_dead, .external_clock_dead, .internal_lock,
    .external_clock_tick, .filter_valid, .filter_divider, .filter_stage, .store_5v, .store_3v,
    .monitor_irq, .clock_select, .internal_gen_run, .external_gen_run, .oscillator_output_enable,
    .multiplier_effective, .oscillator_trim_out, .divider_effective, .stage_out);
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Called just after an edge; the address phase holds until hready is seen high
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask
  task rd(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(0, a, 0, q);
    chk(n, e, q);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task tk(input int n);
    repeat (n) begin
      external_clock_tick <= 1;
      @(posedge clk);
      external_clock_tick <= 0;
      @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    r = $random(seed);
    store_5v <= r[7:0];
    store_3v <= r[15:8];
    cyc(2);
    nrst <= 1;
    cyc(4);
    rd("ctl", `CG_OFS_CONTROL, 8'h08);
    rd("mul", `CG_OFS_MULT, 8'h15);
    rd("trm", `CG_OFS_TRIM, 8'h80);
    rd("t5", `CG_OFS_STORE_5V, store_5v);
    wr(`CG_OFS_STORE_3V, ~store_3v);
    rd("t3", `CG_OFS_STORE_3V, store_3v);
    rd("gap", 32'h0000_0020, 0);
    wr(`CG_OFS_MULT, 0);
    cyc(2);
    chk("m0", 7'h01, multiplier_effective);
    repeat (4) begin
      r = $random(seed);
      wr(`CG_OFS_MULT, r);
      rd("mr", `CG_OFS_MULT, r[6:0]);
      wr(`CG_OFS_TRIM, r);
      cyc(2);
      chk("tr", r[7:0], oscillator_trim_out);
    end
    wr(`CG_OFS_CONTROL, 8'h28);
    rd("mon0", `CG_OFS_CONTROL, 8'h08);
    wr(`CG_OFS_STAGE, 8'h55);
    rd("stg", `CG_OFS_STAGE, 0);
    filter_valid <= 1;
    filter_stage <= r[7:0];
    filter_divider <= 4'hc;
    cyc(4);
    chk("div", 4'h9, divider_effective);
    chk("so", r[7:0], stage_out);
    filter_valid <= 0;
    internal_lock <= 1;
    wr(`CG_OFS_CONTROL, 8'h0A);
    tk(15);
    rd("es0", `CG_OFS_CONTROL, 8'h0E);
    tk(1);
    rd("es1", `CG_OFS_CONTROL, 8'h0F);
    wr(`CG_OFS_CONTROL, 8'h1A);
    cyc(2);
    chk("cs", 1, clock_select);
    wr(`CG_OFS_CONTROL, 8'h3A);
    rd("mon1", `CG_OFS_CONTROL, 8'h3F);
    wr(`CG_OFS_MULT, ~r);
    rd("mlk", `CG_OFS_MULT, r[6:0]);
    wr(`CG_OFS_CONTROL, 8'hBA);
    rd("ie", `CG_OFS_CONTROL, 8'hBF);
    external_clock_dead <= 1;
    cyc(1);
    external_clock_dead <= 0;
    cyc(3);
    chk("irq", 1, monitor_irq);
    rd("flg", `CG_OFS_CONTROL, 8'hEE);
    wr(`CG_OFS_CONTROL, 8'hAE);
    rd("clr", `CG_OFS_CONTROL, 8'hAE);
    chk("irq0", 0, monitor_irq);
    wr(`CG_OFS_CONTROL, 8'h8A);
    rd("off", `CG_OFS_CONTROL, 8'h0E);
    tk(16);
    wr(`CG_OFS_CONTROL, 8'h1A);
    wr(`CG_OFS_CONTROL, 8'h12);
    rd("ioff", `CG_OFS_CONTROL, 8'h13);
    chk("irun", 0, internal_gen_run);
    r = $random(seed);
    wr(`CG_OFS_STAGE, r);
    rd("stw", `CG_OFS_STAGE, r[7:0]);
    stop_mode <= 1;
    cyc(3);
    chk("oe0", 0, oscillator_output_enable);
    chk("erun", 0, external_gen_run);
    rd("stp", `CG_OFS_CONTROL, 8'h12);
    stop_oscillator_option <= 1;
    cyc(3);
    chk("oe1", 1, oscillator_output_enable);
    end_sim;
  end
endmodule
`default_nettype wire
